// ===== verilog/fepc_pkg.sv
package fepc_pkg;
    // Command codes
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h20;
    localparam logic [7:0] CMD_BLOCK_ERASE = 8'h22;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    // Status codes
    localparam logic [7:0] ST_ACK = 8'h06;
    localparam logic [7:0] ST_PARAM_ERR = 8'h05;
    localparam logic [7:0] ST_CSUM_ERR = 8'h07;
    localparam logic [7:0] ST_PROTECT_ERR = 8'h10;
    localparam logic [7:0] ST_NACK = 8'h15;
    localparam logic [7:0] ST_MARGIN_A = 8'h1A;
    localparam logic [7:0] ST_MARGIN_B = 8'h1B;
    localparam logic [7:0] ST_WRITE_ERR = 8'h1C;
    // Flash geometry
    localparam int ADDR_W = 24;
    localparam int BLOCK_BITS = 10;
    localparam logic [23:0] FLASH_LAST = 24'h03FFFF;
    localparam logic [23:0] BOOT_LAST = 24'h000FFF;
    localparam logic [9:0] BLOCK_OFS_ONES = 10'h3FF;
    // Frame checks
    localparam int MAX_DATA_LEN = 256;
    // Flash operation result encoding
    localparam logic [1:0] FRES_OK = 2'h0;
    localparam logic [1:0] FRES_MARGIN_A = 2'h1;
    localparam logic [1:0] FRES_MARGIN_B = 2'h2;
    localparam logic [1:0] FRES_WRITE = 2'h3;
    // Operation kinds to the flash engine
    localparam logic [1:0] OP_ERASE_CHIP = 2'h0;
    localparam logic [1:0] OP_ERASE_RANGE = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_VERIFY = 2'h3;
endpackage : fepc_pkg

// ===== verilog/fepc_range_check.sv
`timescale 1ns/1ps
`default_nettype none
module fepc_range_check (
    // Range
    input wire logic [23:0] startAddr,
    input wire logic [23:0] endAddr,
    input wire logic checkOrder,
    // Security
    input wire logic protectAll,
    input wire logic protectBoot,
    // Result
    output logic paramBad,
    output logic protectBad
);
    always_comb begin
        paramBad = (endAddr > fepc_pkg::FLASH_LAST)
            || (startAddr[fepc_pkg::BLOCK_BITS-1:0] != '0)
            || (endAddr[fepc_pkg::BLOCK_BITS-1:0] != fepc_pkg::BLOCK_OFS_ONES)
            || (checkOrder && (startAddr > endAddr));
        protectBad = protectAll
            || (protectBoot && (startAddr <= fepc_pkg::BOOT_LAST));
    end
endmodule : fepc_range_check
`default_nettype wire

// ===== verilog/fepc_cmd_engine.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Successful erase answers with acknowledge status.
// - Well-formed command frame with bad checksum answers checksum error.
// - Malformed command frame (bad length, no end marker) answers negative acknowledge.
// - Protected chip erase answers protect error.
// - Internal erase failure answers a margin or write failure code.
// - Block erase beyond flash or misaligned answers parameter error.
// - Protected block erase or boot block in range answers protect error.
// - Each data frame of a programming run answers a status frame with two status bytes.
// - Program range outside flash, misaligned or reversed answers parameter error.
module fepc_cmd_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Decoded command frame
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    input wire logic [23:0] cmdStart,
    input wire logic [23:0] cmdEnd,
    input wire logic cmdCsumOk,
    input wire logic cmdFormOk,
    // Decoded data frame
    input wire logic dataValid,
    input wire logic dataLast,
    input wire logic dataCsumOk,
    input wire logic dataFormOk,
    // Security settings
    input wire logic protectErase,
    input wire logic protectWrite,
    input wire logic protectBoot,
    // Flash engine
    output logic flashStart,
    output logic [1:0] flashOp,
    input wire logic flashDone,
    input wire logic [1:0] flashResult,
    // Status frame out
    output logic statusValid,
    output logic statusTwo,
    output logic [7:0] firstStatusByte,
    output logic [7:0] secondStatusByte
);
    // Programming loop and erase each move one bit per step, except the FEPC_WRITE to FEPC_IDLE exit on a write failure
    typedef enum logic [2:0] {
        FEPC_IDLE = 3'b000,
        FEPC_DATA = 3'b001,
        FEPC_WRITE = 3'b011,
        FEPC_VERIFY = 3'b010,
        FEPC_ERASE = 3'b100
    } fepc_state_e;

    fepc_state_e stateReg, stateNext;
    logic [7:0] byteOneReg, byteOneNext;
    logic [7:0] byteTwoReg, byteTwoNext;
    logic statusValidReg, statusValidNext;
    logic statusTwoReg, statusTwoNext;
    logic flashStartReg, flashStartNext;
    logic [1:0] flashOpReg, flashOpNext;
    logic lastReg, lastNext;
    logic paramBad, protectBad, protectSel, orderSel;

    function automatic logic [7:0] failCode(input logic [1:0] res);
        unique case (res)
            fepc_pkg::FRES_OK: failCode = fepc_pkg::ST_ACK;
            fepc_pkg::FRES_MARGIN_A: failCode = fepc_pkg::ST_MARGIN_A;
            fepc_pkg::FRES_MARGIN_B: failCode = fepc_pkg::ST_MARGIN_B;
            fepc_pkg::FRES_WRITE: failCode = fepc_pkg::ST_WRITE_ERR;
        endcase
    endfunction : failCode

    assign orderSel = (cmdCode == fepc_pkg::CMD_PROGRAM);
    assign protectSel = orderSel ? protectWrite : protectErase;

    fepc_range_check rangeCheck (
        .startAddr(cmdStart),
        .endAddr(cmdEnd),
        .checkOrder(orderSel),
        .protectAll(protectSel),
        .protectBoot(protectBoot),
        .paramBad(paramBad),
        .protectBad(protectBad)
    );

    always_comb begin
        stateNext = stateReg;
        byteOneNext = byteOneReg;
        byteTwoNext = byteTwoReg;
        statusValidNext = 1'b0;
        statusTwoNext = statusTwoReg;
        flashStartNext = 1'b0;
        flashOpNext = flashOpReg;
        lastNext = lastReg;
        unique case (stateReg)
            FEPC_IDLE: begin
                if (cmdValid) begin
                    statusTwoNext = 1'b0;
                    statusValidNext = 1'b1;
                    if (!cmdFormOk) begin
                        byteOneNext = fepc_pkg::ST_NACK;
                    end else if (!cmdCsumOk) begin
                        byteOneNext = fepc_pkg::ST_CSUM_ERR;
                    end else if (cmdCode == fepc_pkg::CMD_CHIP_ERASE) begin
                        if (protectErase || protectBoot) begin
                            byteOneNext = fepc_pkg::ST_PROTECT_ERR;
                        end else begin
                            statusValidNext = 1'b0;
                            flashStartNext = 1'b1;
                            flashOpNext = fepc_pkg::OP_ERASE_CHIP;
                            stateNext = FEPC_ERASE;
                        end
                    end else if (cmdCode == fepc_pkg::CMD_BLOCK_ERASE
                            || cmdCode == fepc_pkg::CMD_PROGRAM) begin
                        if (paramBad) begin
                            byteOneNext = fepc_pkg::ST_PARAM_ERR;
                        end else if (protectBad) begin
                            byteOneNext = fepc_pkg::ST_PROTECT_ERR;
                        end else if (orderSel) begin
                            byteOneNext = fepc_pkg::ST_ACK;
                            stateNext = FEPC_DATA;
                        end else begin
                            statusValidNext = 1'b0;
                            flashStartNext = 1'b1;
                            flashOpNext = fepc_pkg::OP_ERASE_RANGE;
                            stateNext = FEPC_ERASE;
                        end
                    end else begin
                        byteOneNext = fepc_pkg::ST_NACK;
                    end
                end
            end
            FEPC_ERASE: begin
                if (flashDone) begin
                    byteOneNext = failCode(flashResult);
                    statusValidNext = 1'b1;
                    stateNext = FEPC_IDLE;
                end
            end
            FEPC_DATA: begin
                if (dataValid) begin
                    statusTwoNext = 1'b1;
                    if (!dataFormOk || !dataCsumOk) begin
                        // Frame faults go in the first byte and abandon the write
                        byteOneNext = dataFormOk ? fepc_pkg::ST_CSUM_ERR : fepc_pkg::ST_NACK;
                        byteTwoNext = fepc_pkg::ST_NACK;
                        statusValidNext = 1'b1;
                        stateNext = FEPC_IDLE;
                    end else begin
                        lastNext = dataLast;
                        flashStartNext = 1'b1;
                        flashOpNext = fepc_pkg::OP_WRITE;
                        stateNext = FEPC_WRITE;
                    end
                end
            end
            FEPC_WRITE: begin
                if (flashDone) begin
                    byteOneNext = fepc_pkg::ST_ACK;
                    byteTwoNext = failCode(flashResult);
                    statusValidNext = 1'b1;
                    if (flashResult != fepc_pkg::FRES_OK) begin
                        stateNext = FEPC_IDLE;
                    end else if (lastReg) begin
                        flashStartNext = 1'b1;
                        flashOpNext = fepc_pkg::OP_VERIFY;
                        stateNext = FEPC_VERIFY;
                    end else begin
                        stateNext = FEPC_DATA;
                    end
                end
            end
            FEPC_VERIFY: begin
                if (flashDone) begin
                    statusTwoNext = 1'b0;
                    byteOneNext = failCode(flashResult);
                    statusValidNext = 1'b1;
                    stateNext = FEPC_IDLE;
                end
            end
            default: stateNext = FEPC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stateReg <= FEPC_IDLE;
            byteOneReg <= 8'h00;
            byteTwoReg <= 8'h00;
            statusValidReg <= 1'b0;
            statusTwoReg <= 1'b0;
            flashStartReg <= 1'b0;
            flashOpReg <= 2'h0;
            lastReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            byteOneReg <= byteOneNext;
            byteTwoReg <= byteTwoNext;
            statusValidReg <= statusValidNext;
            statusTwoReg <= statusTwoNext;
            flashStartReg <= flashStartNext;
            flashOpReg <= flashOpNext;
            lastReg <= lastNext;
        end
    end

    assign statusValid = statusValidReg;
    assign statusTwo = statusTwoReg;
    assign firstStatusByte = byteOneReg;
    assign secondStatusByte = byteTwoReg;
    assign flashStart = flashStartReg;
    assign flashOp = flashOpReg;

    sequence badForm_s;
        stateReg == FEPC_IDLE && cmdValid && !cmdFormOk;
    endsequence
    sequence eraseCmd_s;
        stateReg == FEPC_IDLE && cmdValid && cmdFormOk && cmdCsumOk
            && cmdCode == fepc_pkg::CMD_CHIP_ERASE && !protectErase && !protectBoot;
    endsequence

    nack_answer_a: assert property (@(posedge clk) disable iff (!rst_b)
        badForm_s |=> statusValid && firstStatusByte == fepc_pkg::ST_NACK)
        else $error("malformed frame not nacked");
    csum_answer_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateReg == FEPC_IDLE && cmdValid && cmdFormOk && !cmdCsumOk
        |=> statusValid && firstStatusByte == fepc_pkg::ST_CSUM_ERR)
        else $error("bad checksum not reported");
    chip_protect_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateReg == FEPC_IDLE && cmdValid && cmdFormOk && cmdCsumOk
        && cmdCode == fepc_pkg::CMD_CHIP_ERASE && (protectErase || protectBoot)
        |=> statusValid && firstStatusByte == fepc_pkg::ST_PROTECT_ERR && !flashStart)
        else $error("protected chip erase not refused");
    erase_start_a: assert property (@(posedge clk) disable iff (!rst_b)
        eraseCmd_s |=> flashStart && !statusValid ##1 stateReg == FEPC_ERASE)
        else $error("chip erase not started");
    erase_result_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateReg == FEPC_ERASE && flashDone && flashResult != fepc_pkg::FRES_OK
        |=> statusValid && firstStatusByte != fepc_pkg::ST_ACK)
        else $error("erase failure reported as ack");
    erase_ok_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateReg == FEPC_ERASE && flashDone && flashResult == fepc_pkg::FRES_OK
        |=> statusValid && firstStatusByte == fepc_pkg::ST_ACK && stateReg == FEPC_IDLE)
        else $error("erase success not acked");
    range_param_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateReg == FEPC_IDLE && cmdValid && cmdFormOk && cmdCsumOk && paramBad
        && (cmdCode == fepc_pkg::CMD_BLOCK_ERASE || cmdCode == fepc_pkg::CMD_PROGRAM)
        |=> statusValid && firstStatusByte == fepc_pkg::ST_PARAM_ERR)
        else $error("bad range not refused");
    range_protect_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateReg == FEPC_IDLE && cmdValid && cmdFormOk && cmdCsumOk && !paramBad
        && protectBad && cmdCode == fepc_pkg::CMD_BLOCK_ERASE
        |=> statusValid && firstStatusByte == fepc_pkg::ST_PROTECT_ERR)
        else $error("protected block erase not refused");
    two_byte_a: assert property (@(posedge clk) disable iff (!rst_b)
        stateReg == FEPC_WRITE && flashDone
        |=> statusValid && statusTwo && firstStatusByte == fepc_pkg::ST_ACK)
        else $error("data frame status not two bytes");
endmodule : fepc_cmd_engine
`default_nettype wire

// ===== sim/fepc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fepc_flash_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Requests from the engine
    input wire logic flashStart,
    input wire logic [1:0] flashOp,
    // Behaviour chosen by the bench
    input wire logic [7:0] doneDelay,
    input wire logic [1:0] doneResult,
    // Answer and observation
    output logic flashDone,
    output logic [1:0] flashResult,
    output logic [1:0] lastOp,
    output int nStarts
);
    logic [7:0] cntReg;
    logic busyReg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cntReg <= 8'h00;
            busyReg <= 1'b0;
            flashDone <= 1'b0;
            flashResult <= 2'h0;
            lastOp <= 2'h0;
            nStarts <= 0;
        end else begin
            flashDone <= 1'b0;
            // Result is junk outside the done pulse, so a stale read shows
            flashResult <= ~flashResult;
            if (flashStart) begin
                busyReg <= 1'b1;
                cntReg <= doneDelay;
                lastOp <= flashOp;
                nStarts <= nStarts + 1;
            end else if (busyReg && cntReg == 8'h00) begin
                busyReg <= 1'b0;
                flashDone <= 1'b1;
                flashResult <= doneResult;
            end else if (busyReg) begin
                cntReg <= cntReg - 8'h01;
            end
        end
    end
endmodule : fepc_flash_model
`default_nettype wire

// ===== sim/fepc_cmd_engine_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fepc_cmd_engine_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmdValid = 1'b0;
    logic [7:0] cmdCode = 8'h00;
    logic [23:0] cmdStart = 24'h000000;
    logic [23:0] cmdEnd = 24'h000000;
    logic cmdCsumOk = 1'b1;
    logic cmdFormOk = 1'b1;
    logic dataValid = 1'b0;
    logic dataLast = 1'b0;
    logic dataCsumOk = 1'b1;
    logic dataFormOk = 1'b1;
    logic protectErase = 1'b0;
    logic protectWrite = 1'b0;
    logic protectBoot = 1'b0;
    logic [1:0] doneResult = 2'h0;
    logic [7:0] doneDelay = 8'h00;
    logic flashStart, flashDone, statusValid, statusTwo, two;
    logic [1:0] flashOp, flashResult, lastOp;
    logic [7:0] firstStatusByte, secondStatusByte, s1, s2;
    logic [7:0] cmds [3] = '{fepc_pkg::CMD_CHIP_ERASE, fepc_pkg::CMD_BLOCK_ERASE,
        fepc_pkg::CMD_PROGRAM};
    int nStarts, n0, k, b;
    int n_fail = 0;
    int n_compared = 0;
    // Programmer-side waits and limits, in clock cycles
    localparam int CMD_GAP_TIME = 4;
    localparam int DATA_FRAME_GAP_TIME = 2;
    localparam int CHIP_ERASE_TIMEOUT = 600;
    localparam int BLOCK_ERASE_TIMEOUT = 600;
    localparam int PROGRAM_CMD_TIMEOUT = 8;
    localparam int DATA_FRAME_STATUS_TIMEOUT = 600;
    localparam int PER_BLOCK_VERIFY_TIMEOUT = 100;

    always #4 clk = ~clk;

    fepc_cmd_engine u_fepc_cmd_engine (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdStart(cmdStart), .cmdEnd(cmdEnd), .cmdCsumOk(cmdCsumOk),
        .cmdFormOk(cmdFormOk), .dataValid(dataValid), .dataLast(dataLast),
        .dataCsumOk(dataCsumOk), .dataFormOk(dataFormOk), .protectErase(protectErase),
        .protectWrite(protectWrite), .protectBoot(protectBoot), .flashStart(flashStart),
        .flashOp(flashOp), .flashDone(flashDone), .flashResult(flashResult),
        .statusValid(statusValid), .statusTwo(statusTwo), .firstStatusByte(firstStatusByte),
        .secondStatusByte(secondStatusByte));

    fepc_flash_model u_fepc_flash_model (.clk(clk), .rst_b(rst_b), .flashStart(flashStart),
        .flashOp(flashOp), .doneDelay(doneDelay), .doneResult(doneResult),
        .flashDone(flashDone), .flashResult(flashResult), .lastOp(lastOp), .nStarts(nStarts));

    function automatic logic [7:0] res_code(input logic [1:0] r);
        case (r)
            fepc_pkg::FRES_MARGIN_A: return fepc_pkg::ST_MARGIN_A;
            fepc_pkg::FRES_MARGIN_B: return fepc_pkg::ST_MARGIN_B;
            fepc_pkg::FRES_WRITE: return fepc_pkg::ST_WRITE_ERR;
            default: return fepc_pkg::ST_ACK;
        endcase
    endfunction : res_code

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic summarize;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize

    // Sampled at falling edges, so the one-cycle pulse is seen once
    task automatic get_status(input int limit);
        for (int i = 0; i < limit && statusValid !== 1'b1; i++) @(negedge clk);
        chk("statusValid", statusValid, 1'b1);
        s1 = firstStatusByte;
        s2 = secondStatusByte;
        two = statusTwo;
        @(negedge clk);
    endtask : get_status

    task automatic send_data(input logic last, input logic cs, input logic fm);
        repeat (DATA_FRAME_GAP_TIME) @(negedge clk);
        dataLast = last;
        dataCsumOk = cs;
        dataFormOk = fm;
        dataValid = 1'b1;
        @(negedge clk);
        dataValid = 1'b0;
    endtask : send_data

    task automatic expect_cmd(input logic [7:0] code, input logic [23:0] sa, input logic [23:0] ea,
        input logic cs, input logic fm, input logic [7:0] exp);
        repeat (CMD_GAP_TIME) @(negedge clk);
        cmdCode = code;
        cmdStart = sa;
        cmdEnd = ea;
        cmdCsumOk = cs;
        cmdFormOk = fm;
        cmdValid = 1'b1;
        doneDelay = 8'($urandom_range(0, 40));
        @(negedge clk);
        cmdValid = 1'b0;
        get_status(code == fepc_pkg::CMD_PROGRAM ? PROGRAM_CMD_TIMEOUT
            : code == fepc_pkg::CMD_BLOCK_ERASE ? BLOCK_ERASE_TIMEOUT
            : CHIP_ERASE_TIMEOUT);
        chk("firstStatusByte", s1, exp);
    endtask : expect_cmd

    task automatic run_prog(input logic [23:0] ea, input logic [1:0] wres,
        input logic [1:0] vres);
        int frames;
        int blocks;
        // Range starts at 0x001000; bytes split into 256-byte frames
        frames = (int'(ea) - 4096 + 256) / 256;
        blocks = (int'(ea) - 4096 + 1) / 1024;
        expect_cmd(fepc_pkg::CMD_PROGRAM, 24'h001000, ea, 1'b1, 1'b1, fepc_pkg::ST_ACK);
        if (s1 !== fepc_pkg::ST_ACK) return;
        doneResult = wres;
        for (int f = 0; f < frames; f++) begin
            send_data(f == frames - 1, 1'b1, 1'b1);
            get_status(DATA_FRAME_STATUS_TIMEOUT);
            chk("statusTwo", two, 1'b1);
            chk("data firstStatusByte", s1, fepc_pkg::ST_ACK);
            chk("secondStatusByte", s2, res_code(wres));
            if (s2 !== fepc_pkg::ST_ACK) return;
        end
        doneResult = vres;
        get_status(PER_BLOCK_VERIFY_TIMEOUT * blocks);
        chk("final statusTwo", two, 1'b0);
        chk("final firstStatusByte", s1, res_code(vres));
        chk("flashOp", lastOp, fepc_pkg::OP_VERIFY);
    endtask : run_prog

    initial begin
        #(8 * 40000);
        n_fail++;
        summarize();
    end

    initial begin
        k = $urandom(32'h11DC4B33);
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        for (k = 0; k < 4; k++) begin
            doneResult = 2'(k);
            expect_cmd(cmds[0], 24'h0, 24'h0, 1'b1, 1'b1, res_code(2'(k)));
            chk("flashOp", lastOp, fepc_pkg::OP_ERASE_CHIP);
        end
        for (k = 0; k < 10; k++) begin
            b = $urandom_range(4, 255);
            doneResult = 2'($urandom_range(0, 3));
            protectBoot = 1'($urandom_range(0, 1));
            expect_cmd(cmds[1], {b[13:0], 10'h000}, {6'h00, 8'($urandom_range(b, 255)), 10'h3FF},
                1'b1, 1'b1, res_code(doneResult));
            chk("flashOp", lastOp, fepc_pkg::OP_ERASE_RANGE);
        end
        n0 = nStarts;
        protectBoot = 1'b1;
        expect_cmd(cmds[0], 24'h0, 24'h0, 1'b1, 1'b1, fepc_pkg::ST_PROTECT_ERR);
        expect_cmd(cmds[1], 24'h000C00, 24'h000FFF, 1'b1, 1'b1, fepc_pkg::ST_PROTECT_ERR);
        protectBoot = 1'b0;
        protectErase = 1'b1;
        expect_cmd(cmds[0], 24'h0, 24'h0, 1'b1, 1'b1, fepc_pkg::ST_PROTECT_ERR);
        expect_cmd(cmds[1], 24'h001000, 24'h0013FF, 1'b1, 1'b1, fepc_pkg::ST_PROTECT_ERR);
        protectErase = 1'b0;
        protectWrite = 1'b1;
        expect_cmd(cmds[2], 24'h001000, 24'h0013FF, 1'b1, 1'b1, fepc_pkg::ST_PROTECT_ERR);
        protectWrite = 1'b0;
        expect_cmd(cmds[1], 24'h001000, 24'h0403FF, 1'b1, 1'b1, fepc_pkg::ST_PARAM_ERR);
        expect_cmd(cmds[1], 24'h001001, 24'h0013FF, 1'b1, 1'b1, fepc_pkg::ST_PARAM_ERR);
        expect_cmd(cmds[1], 24'h001000, 24'h0013FE, 1'b1, 1'b1, fepc_pkg::ST_PARAM_ERR);
        expect_cmd(cmds[2], 24'h001400, 24'h0013FF, 1'b1, 1'b1, fepc_pkg::ST_PARAM_ERR);
        expect_cmd(cmds[2], 24'h03FC00, 24'h0403FF, 1'b1, 1'b1, fepc_pkg::ST_PARAM_ERR);
        expect_cmd(cmds[2], 24'h001200, 24'h0013FF, 1'b1, 1'b1, fepc_pkg::ST_PARAM_ERR);
        foreach (cmds[i]) begin
            expect_cmd(cmds[i], 24'h001000, 24'h0013FF, 1'b0, 1'b1, fepc_pkg::ST_CSUM_ERR);
            expect_cmd(cmds[i], 24'h001000, 24'h0013FF, 1'b1, 1'b0, fepc_pkg::ST_NACK);
            expect_cmd(cmds[i], 24'h001000, 24'h0013FF, 1'b0, 1'b0, fepc_pkg::ST_NACK);
        end
        chk("flash starts", nStarts, n0);
        // Data frames outside a programming run must be ignored
        send_data(1'b1, 1'b1, 1'b1);
        repeat (4) begin
            @(negedge clk);
            chk("idle statusValid", statusValid, 1'b0);
        end
        run_prog(24'h0013FF, fepc_pkg::FRES_OK, fepc_pkg::FRES_OK);
        run_prog(24'h0017FF, fepc_pkg::FRES_OK, fepc_pkg::FRES_MARGIN_B);
        run_prog(24'h0013FF, fepc_pkg::FRES_WRITE, fepc_pkg::FRES_OK);
        for (k = 0; k < 2; k++) begin
            expect_cmd(cmds[2], 24'h001000, 24'h0013FF, 1'b1, 1'b1, fepc_pkg::ST_ACK);
            // First pass breaks the checksum, second pass the frame form
            send_data(1'b0, k[0], ~k[0]);
            get_status(DATA_FRAME_STATUS_TIMEOUT);
            chk("data firstStatusByte", s1,
                k[0] ? fepc_pkg::ST_NACK : fepc_pkg::ST_CSUM_ERR);
            chk("data secondStatusByte", s2, fepc_pkg::ST_NACK);
            chk("data statusTwo", two, 1'b1);
        end
        doneResult = fepc_pkg::FRES_OK;
        expect_cmd(cmds[0], 24'h0, 24'h0, 1'b1, 1'b1, fepc_pkg::ST_ACK);
        summarize();
    end
endmodule : fepc_cmd_engine_tb_top
`default_nettype wire
